// ==== core/iic_top.sv ====
// Purpose: Interrupt status, mask, request and control port logic
// Assumes: Single clock, synchronous inputs, plain register port
// Notes: Normal and fast lines are built from separate status sets
// How it works
// - Separate normal and fast request outputs
// - Request is status AND mask; any raises
// - Masks undefined; software writes them first
// - Clear removes latched bits, levels untouched
// - No priority; software reads request bits
// - Eight active-low level normal inputs
// - Acknowledge on falling edge, flyback rising
// - Two high, one low fast inputs
// - Set A bit map fixed
// - Timer bits latched until cleared
// - Set A bit 7 forces normal request
// - Set B bit map fixed
// - Fast status bit map fixed
// - Control read returns live pin levels
// - Open drain: zero drives low, one releases
// - Control register resets to all ones
// - Control bit 7 reads flyback level
// - Bit 6 reads acknowledge; write ones
// - Control bit 5 high mutes speaker
`timescale 1ns/100ps
module iic_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Requests to the core
	output logic irq_o,
	output logic fiq_o,
	// Normal sources
	input wire logic [7:0] low_level_irq_inputs_i,
	input wire logic printer_acknowledge_i,
	input wire logic rising_edge_irq_input_i,
	input wire logic [1:0] timer_events_i,
	input wire logic keyboard_transmit_empty_i,
	input wire logic keyboard_receive_full_i,
	// Fast sources
	input wire logic [1:0] high_level_fast_inputs_i,
	input wire logic low_level_fast_input_i,
	// Control port pins
	input wire logic [5:0] ctrl_pins_i,
	output logic [5:0] ctrl_pins_o,
	output logic [5:0] ctrl_pins_oe_o,
	output logic speaker_silence_o,
	output logic test_mode_o
);

	// Address compare shared by every write strobe decode
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Sticky flag: set wins over clear
	function automatic logic sticky(input logic set,
		input logic clr, input logic q);
		sticky = set | (q & ~clr);
	endfunction

	// Registers
	logic [7:0] ctrl_r; // Control port written value
	logic [7:0] mask_a_r; // Mask for set A
	logic [7:0] mask_b_r; // Mask for set B
	logic [7:0] mask_f_r; // Mask for fast set
	logic por_r; // Power-on flag
	logic [1:0] tm_r; // Latched timer events
	logic frc_irq_r; // Software normal force
	logic frc_fiq_r; // Software fast force
	logic [7:0] rdata_r; // Read data, one cycle after strobe

	// Next values
	logic por_nxt;
	logic [1:0] tm_nxt;
	logic [7:0] rdata_nxt;

	// Decode strobes
	wire logic wr_ctrl = wr_i & hit(addr_i, iic_pkg::OFF_CTRL);
	wire logic wr_clear = wr_i & hit(addr_i, iic_pkg::OFF_CLEAR);
	wire logic wr_mask_a = wr_i & hit(addr_i, iic_pkg::OFF_MASK_A);
	wire logic wr_mask_b = wr_i & hit(addr_i, iic_pkg::OFF_MASK_B);
	wire logic wr_mask_f = wr_i & hit(addr_i, iic_pkg::OFF_MASK_F);
	wire logic wr_force = wr_i & hit(addr_i, iic_pkg::OFF_FORCE);

	// Per-bit clear, only for latched sources
	wire logic [7:0] clr_bits = wr_clear ? wdata_i : iic_pkg::ZERO8;

	// Edge-latched flags
	wire logic printer_acknowledge_flag; // Acknowledge fell
	wire logic fly_flag; // Flyback started

	// Status and request vectors
	logic [7:0] stat_a;
	logic [7:0] stat_b;
	logic [7:0] stat_f;
	wire logic [7:0] req_a;
	wire logic [7:0] req_b;
	wire logic [7:0] req_f;
	wire logic any_a;
	wire logic any_b;
	wire logic any_f;

	// Acknowledge is caught on its falling edge
	iic_edge_latch #(
		.RISE(1'b0)
	) u_printer_acknowledge (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.level_i(printer_acknowledge_i),
		.clear_i(clr_bits[iic_pkg::A_PRINTER_ACKNOWLEDGE]),
		.flag_o(printer_acknowledge_flag)
	);

	// Flyback is caught on its rising edge
	iic_edge_latch #(
		.RISE(1'b1)
	) u_fly (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.level_i(rising_edge_irq_input_i),
		.clear_i(clr_bits[iic_pkg::A_FLY]),
		.flag_o(fly_flag)
	);

	// Power-on and timer flags hold until cleared
	assign por_nxt = sticky(1'b0, clr_bits[iic_pkg::A_POR], por_r);
	always_comb begin
		tm_nxt[0] = sticky(timer_events_i[0],
			clr_bits[iic_pkg::A_TM0], tm_r[0]);
		tm_nxt[1] = sticky(timer_events_i[1],
			clr_bits[iic_pkg::A_TM1], tm_r[1]);
	end

	// Set A: levels follow pins, others are latched
	always_comb begin
		stat_a = iic_pkg::ZERO8;
		stat_a[iic_pkg::A_BUSY] =
			~low_level_irq_inputs_i[iic_pkg::IL_BUSY];
		stat_a[iic_pkg::A_RING] =
			~low_level_irq_inputs_i[iic_pkg::IL_RING];
		stat_a[iic_pkg::A_PRINTER_ACKNOWLEDGE] = printer_acknowledge_flag;
		stat_a[iic_pkg::A_FLY] = fly_flag;
		stat_a[iic_pkg::A_POR] = por_r;
		stat_a[iic_pkg::A_TM0] = tm_r[0];
		stat_a[iic_pkg::A_TM1] = tm_r[1];
		stat_a[iic_pkg::A_FORCE] = frc_irq_r;
	end

	// Set B: six low inputs and the keyboard events
	always_comb begin
		stat_b[5:0] = ~low_level_irq_inputs_i[5:0];
		stat_b[6] = keyboard_transmit_empty_i;
		stat_b[7] = keyboard_receive_full_i;
	end

	// Fast set: two high, one low, port pins, card, force
	always_comb begin
		stat_f[1:0] = high_level_fast_inputs_i;
		stat_f[2] = ~low_level_fast_input_i;
		stat_f[5:iic_pkg::F_CTRL_LO] = ctrl_pins_i[5:3];
		stat_f[iic_pkg::F_CARD] =
			~low_level_irq_inputs_i[iic_pkg::IL_CARD_FAST];
		stat_f[iic_pkg::F_FORCE] = frc_fiq_r;
	end

	// Three independent request gates
	iic_req_gate u_gate_a (
		.status_i(stat_a),
		.mask_i(mask_a_r),
		.request_o(req_a),
		.any_o(any_a)
	);
	iic_req_gate u_gate_b (
		.status_i(stat_b),
		.mask_i(mask_b_r),
		.request_o(req_b),
		.any_o(any_b)
	);
	iic_req_gate u_gate_f (
		.status_i(stat_f),
		.mask_i(mask_f_r),
		.request_o(req_f),
		.any_o(any_f)
	);

	// Normal line from sets A and B, fast line alone; no ranking
	assign irq_o = any_a | any_b;
	assign fiq_o = any_f;

	// Open drain: drive low only where a zero was written
	assign ctrl_pins_o = 6'h00;
	assign ctrl_pins_oe_o = ~ctrl_r[5:0];
	assign speaker_silence_o = ctrl_r[iic_pkg::C_MUTE];
	// A zero in either of the top two bits leaves normal operation
	assign test_mode_o = ~(ctrl_r[iic_pkg::C_PRINTER_ACKNOWLEDGE]
		& ctrl_r[iic_pkg::C_FLY]);

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (addr_i)
			iic_pkg::OFF_CTRL: begin
				rdata_nxt = {rising_edge_irq_input_i,
					printer_acknowledge_i,
					ctrl_pins_i};
			end
			iic_pkg::OFF_STAT_A: begin
				rdata_nxt = stat_a;
			end
			iic_pkg::OFF_REQ_A: begin
				rdata_nxt = req_a;
			end
			iic_pkg::OFF_MASK_A: begin
				rdata_nxt = mask_a_r;
			end
			iic_pkg::OFF_STAT_B: begin
				rdata_nxt = stat_b;
			end
			iic_pkg::OFF_REQ_B: begin
				rdata_nxt = req_b;
			end
			iic_pkg::OFF_MASK_B: begin
				rdata_nxt = mask_b_r;
			end
			iic_pkg::OFF_STAT_F: begin
				rdata_nxt = stat_f;
			end
			iic_pkg::OFF_REQ_F: begin
				rdata_nxt = req_f;
			end
			iic_pkg::OFF_MASK_F: begin
				rdata_nxt = mask_f_r;
			end
			iic_pkg::OFF_FORCE: begin
				rdata_nxt = {6'h00, frc_fiq_r, frc_irq_r};
			end
			default: begin
				rdata_nxt = iic_pkg::ZERO8;
			end
		endcase
		if (!rd_i) begin
			rdata_nxt = iic_pkg::ZERO8;
		end
	end
	assign rdata_o = rdata_r;

	// Control register, all ones after reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_r <= iic_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= wdata_i;
		end
	end

	// Masks; the zero reset is only one legal undefined value
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask_a_r <= iic_pkg::MASK_RESET;
			mask_b_r <= iic_pkg::MASK_RESET;
			mask_f_r <= iic_pkg::MASK_RESET;
		end else begin
			if (wr_mask_a) begin
				mask_a_r <= wdata_i;
			end
			if (wr_mask_b) begin
				mask_b_r <= wdata_i;
			end
			if (wr_mask_f) begin
				mask_f_r <= wdata_i;
			end
		end
	end

	// Latched flags; power-on flag starts set
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_r <= 1'b1;
			tm_r <= 2'b00;
		end else begin
			por_r <= por_nxt;
			tm_r <= tm_nxt;
		end
	end

	// Software force bits, written as a pair
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frc_irq_r <= 1'b0;
			frc_fiq_r <= 1'b0;
		end else if (wr_force) begin
			frc_irq_r <= wdata_i[iic_pkg::FRC_IRQ];
			frc_fiq_r <= wdata_i[iic_pkg::FRC_FIQ];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= iic_pkg::ZERO8;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Checks on the request and control paths
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Normal line tracks both masked sets
	irq_from_masks_a: assert property (
		irq_o == |((stat_a & mask_a_r) | (stat_b & mask_b_r)))
		else $error("normal request mismatch");
	// Fast line depends only on its own set
	fiq_own_set_a: assert property (
		fiq_o == |(stat_f & mask_f_r))
		else $error("fast request mismatch");
	// A held low set B input with its mask set raises the normal line
	low_level_b_a: assert property (
		|(~low_level_irq_inputs_i[5:0] & mask_b_r[5:0]) |-> irq_o)
		else $error("set B level lost");
	// Acknowledge falling edge latches next cycle
	printer_acknowledge_fall_a: assert property (
		$fell(printer_acknowledge_i) |=> stat_a[iic_pkg::A_PRINTER_ACKNOWLEDGE])
		else $error("acknowledge edge lost");
	// Flyback rising edge latches, then holds unless cleared
	fly_rise_a: assert property (
		$rose(rising_edge_irq_input_i) |=> stat_a[iic_pkg::A_FLY]
		##1 (stat_a[iic_pkg::A_FLY] || $past(clr_bits[iic_pkg::A_FLY])))
		else $error("flyback edge lost");
	// Timer flag holds without a clear
	timer_hold_a: assert property (
		tm_r[0] && !clr_bits[iic_pkg::A_TM0] |=> tm_r[0])
		else $error("timer flag dropped");
	// Clear removes a latched flag unless a new event arrives
	clear_wins_a: assert property (
		clr_bits[iic_pkg::A_TM1] && !timer_events_i[1] |=> !tm_r[1])
		else $error("timer flag not cleared");
	// Control read returns pins one cycle later
	ctrl_read_a: assert property (
		rd_i && addr_i == iic_pkg::OFF_CTRL |=> rdata_o ==
		{$past(rising_edge_irq_input_i), $past(printer_acknowledge_i),
		$past(ctrl_pins_i)})
		else $error("control read mismatch");
	// A written zero drives its pin on the next cycle
	ctrl_drive_a: assert property (
		wr_ctrl |=> ctrl_pins_oe_o == ~$past(wdata_i[5:0]))
		else $error("pin enable mismatch");
	// Normal force with a set mask raises the normal line
	force_irq_a: assert property (
		wr_force && wdata_i[iic_pkg::FRC_IRQ]
		&& mask_a_r[iic_pkg::A_FORCE] && !wr_mask_a |=> irq_o)
		else $error("force did not raise request");

endmodule

// ==== core/iic_pkg.sv ====
// Purpose: Shared constants for the interrupt and control port block
// Assumes: 8-bit register port, byte addresses below
// Notes: Offsets follow a word-spaced map; all values live here
package iic_pkg;
	// Register byte addresses
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT_A = 8'h10;
	localparam logic [7:0] OFF_REQ_A = 8'h14;
	localparam logic [7:0] OFF_CLEAR = 8'h14;
	localparam logic [7:0] OFF_MASK_A = 8'h18;
	localparam logic [7:0] OFF_STAT_B = 8'h20;
	localparam logic [7:0] OFF_REQ_B = 8'h24;
	localparam logic [7:0] OFF_MASK_B = 8'h28;
	localparam logic [7:0] OFF_STAT_F = 8'h30;
	localparam logic [7:0] OFF_REQ_F = 8'h34;
	localparam logic [7:0] OFF_MASK_F = 8'h38;
	localparam logic [7:0] OFF_FORCE = 8'h3C;
	// Status set A bit positions
	localparam int A_BUSY = 0;
	localparam int A_RING = 1;
	localparam int A_PRINTER_ACKNOWLEDGE = 2;
	localparam int A_FLY = 3;
	localparam int A_POR = 4;
	localparam int A_TM0 = 5;
	localparam int A_TM1 = 6;
	localparam int A_FORCE = 7;
	// Low-level input positions used for the printer, ring and fast card bits
	localparam int IL_BUSY = 6;
	localparam int IL_RING = 7;
	localparam int IL_CARD_FAST = 0;
	// Fast status bit positions
	localparam int F_CTRL_LO = 3;
	localparam int F_CARD = 6;
	localparam int F_FORCE = 7;
	// Force register bits: bit 0 normal force, bit 1 fast force
	localparam int FRC_IRQ = 0;
	localparam int FRC_FIQ = 1;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'hFF;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	// Control register bit positions
	localparam int C_MUTE = 5;
	localparam int C_PRINTER_ACKNOWLEDGE = 6;
	localparam int C_FLY = 7;
	localparam int CTRL_PINS = 6;
endpackage

// ==== core/iic_edge_latch.sv ====
// Purpose: Sticky flag set by one edge of a level input
// Assumes: Input is synchronous to clk_i
// Notes: A set in the clearing cycle wins over the clear
`timescale 1ns/100ps
module iic_edge_latch #(
	parameter bit RISE = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Source and clear
	input wire logic level_i,
	input wire logic clear_i,
	// Latched flag
	output logic flag_o
);
	logic prev_r; // Last sampled level
	logic flag_r; // Sticky flag
	wire logic edge_seen; // Chosen edge in this cycle
	wire logic flag_nxt; // Next flag value

	assign edge_seen = RISE ? (level_i & ~prev_r) : (~level_i & prev_r);
	assign flag_nxt = edge_seen | (flag_r & ~clear_i);
	assign flag_o = flag_r;

	// Idle level is the one before the chosen edge
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_r <= ~RISE;
			flag_r <= 1'b0;
		end else begin
			prev_r <= level_i;
			flag_r <= flag_nxt;
		end
	end
endmodule

// ==== core/iic_req_gate.sv ====
// Purpose: Status AND mask into request bits and one summary line
// Assumes: Purely combinational
// Notes: No priority among bits; software reads request bits
`timescale 1ns/100ps
module iic_req_gate (
	// Status and mask
	input wire logic [7:0] status_i,
	input wire logic [7:0] mask_i,
	// Request bits and summary
	output logic [7:0] request_o,
	output logic any_o
);
	// Masked requests and their OR
	assign request_o = status_i & mask_i;
	assign any_o = |request_o;
endmodule

// ==== sim/iic_core_model.sv ====
// Purpose: Far side of the block: core taking requests, port wiring
// Assumes: Port pins carry pull-ups; outside parts may pull them low
// Notes: Core samples both request lines on every clock
`timescale 1ns/100ps
module iic_core_model (
	// Clock
	input wire logic clk_i,
	// Requests from the block
	input wire logic irq_i,
	input wire logic fiq_i,
	// Pin drive from the block and from outside parts
	input wire logic [5:0] dat_i,
	input wire logic [5:0] oe_i,
	input wire logic [5:0] ext_low_i,
	// Resolved pins and sampled requests
	output logic [5:0] pins_o,
	output logic [1:0] seen_o
);
	// Wired-AND of all drivers, pull-up when nobody drives
	assign pins_o = ~((oe_i & ~dat_i) | ext_low_i);
	// Core samples fast in bit 1, normal in bit 0
	always_ff @(posedge clk_i) begin
		seen_o <= {fiq_i, irq_i};
	end
endmodule

// ==== sim/iic_top_tb.sv ====
// Purpose: Self-checking bench for the interrupt and control block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Table rows cover level sources; edges and port by hand
`timescale 1ns/100ps
module iic_top_tb;
	// Row of level inputs beside expected status and requests
	typedef struct {
		logic [7:0] lli;
		logic [1:0] kb;
		logic [1:0] hf;
		logic lf;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] f;
		logic [7:0] rf;
		logic [1:0] seen;
	} iic_row_t;
	// Clock, reset and register port
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'h0;
	logic rd_i = 1'h0;
	logic [7:0] rdata_o;
	logic irq_o;
	logic fiq_o;
	// Sources, kb is {receive full, transmit empty}
	logic [7:0] lli = 8'hFF;
	logic ack = 1'h1;
	logic fly = 1'h0;
	logic [1:0] tm = 2'h0;
	logic [1:0] kb = 2'h0;
	logic [1:0] hf = 2'h0;
	logic lf = 1'h1;
	// Port pins and outputs
	logic [5:0] ext_low = 6'h00;
	logic [5:0] pins;
	logic [5:0] pdat;
	logic [5:0] poe;
	logic spk;
	logic tmode;
	logic [1:0] seen;
	logic [7:0] rv;
	int bad_count = 0;
	int comparisons = 0;
	// Masks: A off, B all, fast 0xC7 so the pin bits stay quiet
	iic_row_t rows [4] = '{
		'{8'hFF, 2'h0, 2'h0, 1'h1, 8'h00, 8'h00, 8'h38, 8'h00, 2'h0},
		'{8'hFE, 2'h0, 2'h0, 1'h1, 8'h00, 8'h01, 8'h78, 8'h40, 2'h3},
		'{8'hDF, 2'h3, 2'h1, 1'h0, 8'h00, 8'hE0, 8'h3D, 8'h05, 2'h3},
		'{8'h00, 2'h1, 2'h2, 1'h1, 8'h03, 8'h7F, 8'h7A, 8'h42, 2'h3}
	};

	iic_top u_iic_top (
		.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.irq_o(irq_o), .fiq_o(fiq_o), .low_level_irq_inputs_i(lli),
		.printer_acknowledge_i(ack), .rising_edge_irq_input_i(fly),
		.timer_events_i(tm), .keyboard_transmit_empty_i(kb[0]),
		.keyboard_receive_full_i(kb[1]), .high_level_fast_inputs_i(hf),
		.low_level_fast_input_i(lf), .ctrl_pins_i(pins),
		.ctrl_pins_o(pdat), .ctrl_pins_oe_o(poe),
		.speaker_silence_o(spk), .test_mode_o(tmode)
	);
	iic_core_model u_iic_core_model (
		.clk_i(clk_i), .irq_i(irq_o), .fiq_i(fiq_o), .dat_i(pdat),
		.oe_i(poe), .ext_low_i(ext_low), .pins_o(pins), .seen_o(seen)
	);

	// Free-running 10 MHz clock
	always #50 clk_i = ~clk_i;

	// Compare and count, report at once on a mismatch
	task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
		comparisons++;
		if (seen_v !== exp_v) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen_v, exp_v);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'h1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'h0;
		#1;
	endtask
	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_i <= 1'h1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1;
		d = rdata_o;
	endtask
	// Verdict and end of run
	task automatic stop_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the hundred-odd cycles the tests take
	initial begin
		#2000000;
		bad_count++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'h1;
		rd(iic_pkg::OFF_CTRL, rv);
		chk(rv, 8'h7F);
		chk({2'h0, poe}, 8'h00);
		chk({7'h0, spk}, 8'h01);
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h10);
		// Masks written before requests are relied on, normal set A off
		wr(iic_pkg::OFF_CLEAR, 8'h10);
		wr(iic_pkg::OFF_MASK_A, 8'h00);
		wr(iic_pkg::OFF_MASK_B, 8'hFF);
		wr(iic_pkg::OFF_MASK_F, 8'hC7);
		foreach (rows[i]) begin
			@(posedge clk_i);
			lli <= rows[i].lli;
			kb <= rows[i].kb;
			hf <= rows[i].hf;
			lf <= rows[i].lf;
			rd(iic_pkg::OFF_STAT_A, rv);
			chk(rv, rows[i].a);
			rd(iic_pkg::OFF_STAT_B, rv);
			chk(rv, rows[i].b);
			rd(iic_pkg::OFF_REQ_B, rv);
			chk(rv, rows[i].b);
			rd(iic_pkg::OFF_STAT_F, rv);
			chk(rv, rows[i].f);
			rd(iic_pkg::OFF_REQ_F, rv);
			chk(rv, rows[i].rf);
			chk({6'h0, seen}, {6'h0, rows[i].seen});
		end
		// Edge sources and a one-cycle timer pulse
		@(posedge clk_i);
		lli <= 8'hFF;
		kb <= 2'h0;
		hf <= 2'h0;
		lf <= 1'h1;
		wr(iic_pkg::OFF_MASK_B, 8'h00);
		wr(iic_pkg::OFF_MASK_F, 8'h80);
		wr(iic_pkg::OFF_MASK_A, 8'hEC);
		@(posedge clk_i);
		ack <= 1'h0;
		fly <= 1'h1;
		tm <= 2'h1;
		@(posedge clk_i);
		tm <= 2'h0;
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h2C);
		chk({7'h0, irq_o}, 8'h01);
		wr(iic_pkg::OFF_CLEAR, 8'h00);
		rd(iic_pkg::OFF_REQ_A, rv);
		chk(rv, 8'h2C);
		// Clear all while a timer fires and a level source is held
		@(posedge clk_i);
		wr_i <= 1'h1;
		addr_i <= iic_pkg::OFF_CLEAR;
		wdata_i <= 8'hFF;
		tm <= 2'h2;
		lli <= 8'hBF;
		@(posedge clk_i);
		wr_i <= 1'h0;
		tm <= 2'h0;
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h41);
		@(posedge clk_i);
		lli <= 8'hFF;
		wr(iic_pkg::OFF_CLEAR, 8'h40);
		chk({7'h0, irq_o}, 8'h00);
		// Software force of each line
		wr(iic_pkg::OFF_FORCE, 8'h01);
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h80);
		chk({6'h0, seen}, 8'h01);
		wr(iic_pkg::OFF_FORCE, 8'h02);
		rd(iic_pkg::OFF_STAT_F, rv);
		chk(rv, 8'hB8);
		chk({6'h0, seen}, 8'h02);
		wr(iic_pkg::OFF_FORCE, 8'h00);
		// Control port: every bit but 5 kept high, speaker on
		wr(iic_pkg::OFF_CTRL, 8'hDF);
		chk({2'h0, poe}, 8'h20);
		chk({7'h0, spk}, 8'h00);
		@(posedge clk_i);
		ext_low <= 6'h01;
		rd(iic_pkg::OFF_CTRL, rv);
		chk(rv, 8'h9E);
		wr(iic_pkg::OFF_CTRL, 8'h7F);
		chk({7'h0, tmode}, 8'h01);
		wr(iic_pkg::OFF_CTRL, 8'hFF);
		chk({7'h0, tmode}, 8'h00);
		// Read-only write ignored, unmapped read, data stands one cycle
		wr(iic_pkg::OFF_STAT_A, 8'hFF);
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h00);
		rd(8'h04, rv);
		chk(rv, 8'h00);
		rd(iic_pkg::OFF_CTRL, rv);
		@(posedge clk_i);
		#1;
		chk(rdata_o, 8'h00);
		// Second reset in mid-run with flyback high, ack low; both
		// detectors restart at their idle level, so both latch
		wr(iic_pkg::OFF_CTRL, 8'hC0);
		@(posedge clk_i);
		rstn_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'h1;
		rd(iic_pkg::OFF_STAT_A, rv);
		chk(rv, 8'h1C);
		rd(iic_pkg::OFF_CTRL, rv);
		chk(rv, 8'hBE);
		chk({7'h0, spk}, 8'h01);
		stop_test();
	end
endmodule
